// *** dv/serial_node.sv ***
/*
 * Remote serial node facing the transceiver's tx and rx lines.
 * Assumes the bench sets bit_clks to the transceiver's bit time in clocks.
 */
`timescale 1ns/1ps
module serial_node (
    input wire logic i_clk,
    input wire logic i_txd,
    output logic o_rxd
);
    int bit_clks = 16;
    // The line idles high between frames, as on a pulled-up wire
    initial o_rxd = 1'b1;

    // Start bit, then n bits first bit first, then one idle bit time
    task automatic send_bits(input int n, input logic [11:0] bits);
        o_rxd <= 1'b0;
        repeat (bit_clks) @(posedge i_clk);
        for (int i = 0; i < n; i++) begin
            o_rxd <= bits[i];
            repeat (bit_clks) @(posedge i_clk);
        end
        o_rxd <= 1'b1;
        repeat (bit_clks) @(posedge i_clk);
    endtask

    // Waits a bounded time for a start bit, then samples n bits mid-bit
    task automatic grab_bits(input int n, input int limit, output logic [11:0] bits,
                             output bit seen);
        bits = 12'h000;
        seen = 1'b0;
        for (int t = 0; t < limit && !seen; t++) begin
            @(posedge i_clk);
            if (i_txd === 1'b0) seen = 1'b1;
        end
        if (seen) begin
            repeat (bit_clks / 2) @(posedge i_clk);
            for (int i = 0; i < n; i++) begin
                repeat (bit_clks) @(posedge i_clk);
                bits[i] = i_txd;
            end
        end
    endtask
endmodule // serial_node

// *** dv/tb_top.sv ***
/*
 * Self-checking bench for the serial transceiver's register side and lines.
 * Assumes the remote serial node model and a baud prescale of zero.
 */
`timescale 1ns/1ps
module tb_top;
    typedef struct {logic [2:0] sz; logic [8:0] chr; int n; logic [8:0] exp;} row_s;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [1:0] i_addr = 2'h0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_global_ie = 1'b0;
    logic i_tx_irq_ack = 1'b0;
    logic [11:0] i_baud_div = 12'h000;
    logic i_rxd;
    logic [7:0] o_rdata;
    logic o_txd, o_tx_pin_owned, o_rx_pin_owned, o_irq_rx, o_irq_tx, o_irq_empty;
    int failures = 0;
    int n_compared = 0;
    logic [7:0] v;
    logic [11:0] fr;
    logic [11:0] got;
    logic ov;
    bit seen;
    row_s rows [5] = '{'{3'h0, 9'h1a7, 5, 9'h007}, '{3'h1, 9'h0a7, 6, 9'h027},
        '{3'h2, 9'h0a7, 7, 9'h027}, '{3'h3, 9'h1a7, 8, 9'h0a7}, '{3'h7, 9'h15a, 9, 9'h15a}};

    always #5 i_clk = ~i_clk;

    uart_buffer_status_multiproc_filter uart_buffer_status_multiproc_filter_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_baud_div(i_baud_div), .i_global_ie(i_global_ie), .i_tx_irq_ack(i_tx_irq_ack),
        .i_rxd(i_rxd), .o_txd(o_txd), .o_tx_pin_owned(o_tx_pin_owned),
        .o_rx_pin_owned(o_rx_pin_owned), .o_irq_rx(o_irq_rx), .o_irq_tx(o_irq_tx),
        .o_irq_empty(o_irq_empty));
    serial_node serial_node_inst (.i_clk(i_clk), .i_txd(o_txd), .o_rxd(i_rxd));

    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] seen_v);
        n_compared++;
        if (seen_v !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen_v);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic seen_b);
        n_compared++;
        if (seen_b !== exp) begin
            failures++;
            $display("mismatch %s expected %b seen %b", what, exp, seen_b);
        end
    endtask

    // Hold keeps the strobe up so a second write follows with no gap
    task automatic wr(input logic [1:0] a, input logic [7:0] d, input bit hold);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        if (!hold) begin
            i_wr <= 1'b0;
            @(posedge i_clk);
        end
    endtask

    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask

    task automatic close_out;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge i_clk);
        failures++;
        $display("mismatch run_length expected finish seen timeout");
        close_out();
    end

    initial begin
        repeat (16) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (3) @(posedge i_clk);
        rd(2'h1, v);
        chk("csa reset", 12'h020, 12'(v));
        rd(2'h2, v);
        chk("csb reset", 12'h000, 12'(v));
        rd(2'h3, v);
        chk("csc reset", 12'h006, 12'(v));
        $display("test reset done");
        foreach (rows[i]) begin
            wr(2'h3, {5'h00, rows[i].sz[1:0], 1'b0}, 1'b0);
            wr(2'h2, {5'h03, rows[i].sz[2], 1'b0, rows[i].chr[8]}, 1'b0);
            wr(2'h0, rows[i].chr[7:0], 1'b0);
            fr = 12'(rows[i].exp) | (12'h001 << rows[i].n);
            serial_node_inst.grab_bits(rows[i].n + 1, 400, got, seen);
            chk_bit("tx start", 1'b1, seen);
            chk("tx frame", fr, got);
            serial_node_inst.send_bits(rows[i].n + 1, fr);
            rd(2'h2, v);
            if (rows[i].n == 9) chk_bit("rx ninth", rows[i].exp[8], v[1]);
            rd(2'h0, v);
            chk("rx data", 12'(rows[i].exp[7:0]), 12'(v));
            $display("row %0d done", i);
        end
        wr(2'h3, 8'h06, 1'b0);
        wr(2'h2, 8'h68, 1'b0);
        i_global_ie <= 1'b1;
        wr(2'h0, 8'h3c, 1'b1);
        wr(2'h0, 8'hc3, 1'b0);
        serial_node_inst.grab_bits(9, 400, got, seen);
        chk("tx kept", 12'h13c, got);
        serial_node_inst.grab_bits(9, 64, got, seen);
        chk_bit("tx dropped", 1'b0, seen);
        rd(2'h1, v);
        chk_bit("tx complete", 1'b1, v[6]);
        chk_bit("irq tx", 1'b1, o_irq_tx);
        chk_bit("irq empty", 1'b1, o_irq_empty);
        i_global_ie <= 1'b0;
        i_tx_irq_ack <= 1'b1;
        @(posedge i_clk);
        i_tx_irq_ack <= 1'b0;
        rd(2'h1, v);
        chk_bit("tx complete ack", 1'b0, v[6]);
        chk_bit("irq empty gated", 1'b0, o_irq_empty);
        wr(2'h0, 8'h55, 1'b1);
        wr(2'h2, 8'h40, 1'b0);
        repeat (4) @(posedge i_clk);
        chk_bit("tx owned", 1'b1, o_tx_pin_owned);
        serial_node_inst.grab_bits(9, 400, got, seen);
        chk("tx drain", 12'h155, got);
        repeat (16) @(posedge i_clk);
        chk_bit("tx released", 1'b0, o_tx_pin_owned);
        wr(2'h1, 8'h40, 1'b0);
        rd(2'h1, v);
        chk_bit("tx complete w1c", 1'b0, v[6]);
        $display("test transmit done");
        wr(2'h1, 8'h02, 1'b0);
        wr(2'h2, 8'h08, 1'b0);
        serial_node_inst.bit_clks = 8;
        wr(2'h0, 8'h96, 1'b0);
        serial_node_inst.grab_bits(9, 400, got, seen);
        chk("double speed", 12'h196, got);
        serial_node_inst.bit_clks = 16;
        repeat (16) @(posedge i_clk);
        wr(2'h1, 8'h00, 1'b0);
        $display("test double speed done");
        wr(2'h2, 8'h14, 1'b0);
        wr(2'h1, 8'h01, 1'b0);
        serial_node_inst.send_bits(10, 12'h211);
        serial_node_inst.send_bits(10, 12'h322);
        rd(2'h1, v);
        chk_bit("addr accepted", 1'b1, v[7]);
        rd(2'h2, v);
        chk_bit("addr marker", 1'b1, v[1]);
        rd(2'h0, v);
        chk("addr data", 12'h022, 12'(v));
        rd(2'h1, v);
        chk_bit("data dropped", 1'b0, v[7]);
        wr(2'h1, 8'h00, 1'b0);
        serial_node_inst.send_bits(10, 12'h211);
        rd(2'h0, v);
        chk("data after select", 12'h011, 12'(v));
        wr(2'h2, 8'h10, 1'b0);
        wr(2'h1, 8'h01, 1'b0);
        serial_node_inst.send_bits(10, 12'h311);
        rd(2'h0, v);
        chk("stop marker", 12'h011, 12'(v));
        wr(2'h1, 8'h00, 1'b0);
        $display("test filter done");
        wr(2'h2, 8'h90, 1'b0);
        i_global_ie <= 1'b1;
        chk_bit("rx owned", 1'b1, o_rx_pin_owned);
        for (int k = 0; k < 4; k++) serial_node_inst.send_bits(9, 12'h141 + 12'(k));
        ov = 1'b0;
        for (int k = 0; k < 3; k++) begin
            rd(2'h1, v);
            ov = ov | v[3];
            chk_bit("rx complete", 1'b1, v[7]);
            chk_bit("irq rx", 1'b1, o_irq_rx);
            rd(2'h0, v);
            chk("fifo order", 12'h041 + 12'(k), 12'(v));
        end
        chk_bit("overrun", 1'b1, ov);
        rd(2'h1, v);
        chk_bit("fifo empty", 1'b0, v[7]);
        chk_bit("irq rx idle", 1'b0, o_irq_rx);
        $display("test fifo done");
        wr(2'h3, 8'h26, 1'b0);
        serial_node_inst.send_bits(10, 12'h201);
        serial_node_inst.send_bits(10, 12'h000);
        rd(2'h1, v);
        chk("head errors", 12'h001, {10'h000, v[4], v[2]});
        rd(2'h0, v);
        chk("errored data", 12'h001, 12'(v));
        rd(2'h1, v);
        chk("next errors", 12'h002, {10'h000, v[4], v[2]});
        wr(2'h2, 8'h00, 1'b0);
        rd(2'h1, v);
        chk("flushed", 12'h000, {10'h000, v[7], v[4]});
        chk_bit("rx released", 1'b0, o_rx_pin_owned);
        $display("test errors done");
        close_out();
    end
endmodule // tb_top

// *** verilog/uart_buffer_status_multiproc_filter.sv ***
/*
 * Serial transceiver: data window, two-entry receive FIFO, status flags, enables,
 * character size and multi-processor address filter, plus a simple bit engine.
 * Assumes a single clock, a one-cycle register port and an asynchronous rx pin.
 */
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
`include "uart_cfg.svh"
module uart_buffer_status_multiproc_filter #(
    parameter int BAUD_W = 12
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic [BAUD_W-1:0] i_baud_div,
    input wire logic i_global_ie,
    input wire logic i_tx_irq_ack,
    input wire logic i_rxd,
    output logic o_txd,
    output logic o_tx_pin_owned,
    output logic o_rx_pin_owned,
    output logic o_irq_rx,
    output logic o_irq_tx,
    output logic o_irq_empty
);
    logic rst_s1_r, rst_n_r;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_s1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r <= rst_s1_r;
        end
    end
    logic rxd_s1_r, rxd_r;
    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rxd_s1_r <= 1'b1;
            rxd_r <= 1'b1;
        end else begin
            rxd_s1_r <= i_rxd;
            rxd_r <= rxd_s1_r;
        end
    end

    // Control state
    logic dbl_r, mpf_r, rxie_r, txie_r, eie_r, rxon_r, txon_req_r, txon_r, szh_r, tx9_r;
    logic [7:0] csc_r;
    logic txc_r, tx_buffer_empty_r;
    logic [8:0] txbuf_r;
    logic [7:0] rdata_r;

    wire wr_data = i_wr && i_addr == `ADR_DATA;
    wire wr_csa = i_wr && i_addr == `ADR_CSA;
    wire wr_csb = i_wr && i_addr == `ADR_CSB;
    wire wr_csc = i_wr && i_addr == `ADR_CSC;
    wire rd_data = i_rd && i_addr == `ADR_DATA;
    wire [2:0] size_code = {szh_r, csc_r[`CSC_SZ1], csc_r[`CSC_SZ0]};
    wire nine_bit = size_code == 3'h7;
    wire [3:0] nbits = nine_bit ? 4'h9 : {2'h0, size_code[1:0]} + 4'h5;
    wire [4:0] div_sel = dbl_r ? `DIV_DOUBLE : `DIV_NORMAL;
    wire par_en = csc_r[`CSC_PEN];

    function automatic logic [8:0] mask_char(input logic [8:0] d, input logic [3:0] n);
        logic [8:0] m;
        m = 9'h1ff >> (4'h9 - n);
        return d & m;
    endfunction

    // Baud tick: divisor of i_baud_div+1 times div_sel
    logic [BAUD_W-1:0] pre_r;
    logic [`DIV_BITS-1:0] sub_r;
    logic tick_r;
    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            pre_r <= '0;
            sub_r <= '0;
            tick_r <= 1'b0;
        end else begin
            tick_r <= 1'b0;
            if (pre_r == i_baud_div) begin
                pre_r <= '0;
                if (sub_r >= div_sel - 5'h1) begin
                    sub_r <= '0;
                    tick_r <= 1'b1;
                end else begin
                    sub_r <= sub_r + 5'h1;
                end
            end else begin
                pre_r <= pre_r + 1'b1;
            end
        end
    end

    // Transmitter
    uart_pkg::tx_state_e tx_st_r;
    logic [8:0] tx_sh_r;
    logic [3:0] tx_cnt_r;
    logic tx_par_r, txd_r;
    logic tx_busy;
    assign tx_busy = tx_st_r != uart_pkg::TX_IDLE;
    wire tx_load = txon_r && !tx_buffer_empty_r && !tx_busy;
    wire tx_done = tx_busy && tick_r && tx_st_r == uart_pkg::TX_STOP && tx_cnt_r == 4'h0;
    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            tx_st_r <= uart_pkg::TX_IDLE;
            tx_sh_r <= '0;
            tx_cnt_r <= '0;
            tx_par_r <= 1'b0;
            txd_r <= 1'b1;
        end else begin
            case (tx_st_r)
                uart_pkg::TX_IDLE: begin
                    txd_r <= 1'b1;
                    if (tx_load) begin
                        tx_sh_r <= txbuf_r;
                        tx_par_r <= csc_r[`CSC_PODD];
                        tx_cnt_r <= nbits;
                        tx_st_r <= uart_pkg::TX_START;
                    end
                end
                uart_pkg::TX_START: if (tick_r) begin
                    txd_r <= 1'b0;
                    tx_st_r <= uart_pkg::TX_DATA;
                end
                uart_pkg::TX_DATA: if (tick_r) begin
                    if (tx_cnt_r != 4'h0) begin
                        txd_r <= tx_sh_r[0];
                        tx_par_r <= tx_par_r ^ tx_sh_r[0];
                        tx_sh_r <= tx_sh_r >> 1;
                        tx_cnt_r <= tx_cnt_r - 4'h1;
                    end else begin
                        txd_r <= par_en ? tx_par_r : 1'b1;
                        tx_cnt_r <= {3'h0, csc_r[`CSC_STOP2]} + {3'h0, par_en};
                        tx_st_r <= uart_pkg::TX_STOP;
                    end
                end
                uart_pkg::TX_STOP: if (tick_r) begin
                    txd_r <= 1'b1;
                    if (tx_cnt_r == 4'h0) begin
                        tx_st_r <= uart_pkg::TX_IDLE;
                    end else begin
                        tx_cnt_r <= tx_cnt_r - 4'h1;
                    end
                end
                default: tx_st_r <= uart_pkg::TX_IDLE;
            endcase
        end
    end

    // Receiver bit engine, one sample per bit tick
    uart_pkg::rx_state_e rx_st_r;
    logic [8:0] rx_sh_r;
    logic [3:0] rx_cnt_r;
    logic rx_par_r, rx_pend_r, rx_perr_r;
    logic [11:0] rx_hold_r;
    wire rx_start = rxon_r && rxd_r == 1'b0 && rx_st_r == uart_pkg::RX_IDLE;
    // Receive bit timer restarts on the start edge so samples land mid-bit
    logic [BAUD_W-1:0] rx_pre_r;
    logic [`DIV_BITS-1:0] rx_sub_r;
    logic rx_tick_r;
    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rx_pre_r <= '0;
            rx_sub_r <= '0;
            rx_tick_r <= 1'b0;
        end else begin
            rx_tick_r <= 1'b0;
            if (rx_start) begin
                rx_pre_r <= '0;
                rx_sub_r <= {1'b0, div_sel[4:1]};
            end else if (rx_pre_r == i_baud_div) begin
                rx_pre_r <= '0;
                rx_sub_r <= (rx_sub_r >= div_sel - 5'h1) ? 5'h00 : rx_sub_r + 5'h1;
                rx_tick_r <= rx_sub_r >= div_sel - 5'h1;
            end else begin
                rx_pre_r <= rx_pre_r + 1'b1;
            end
        end
    end
    wire rx_frame = rx_tick_r && rx_st_r == uart_pkg::RX_STOP;
    wire rx_stop_ok = rxd_r;
    wire rx_marker = nine_bit ? rx_sh_r[8] : rx_stop_ok;
    wire [8:0] rx_char = mask_char(rx_sh_r >> (4'h9 - nbits), nbits);
    wire rx_keep = !mpf_r || rx_marker;

    logic [11:0] fifo_r [2]; // {dor, upe, fe, ninth/char}
    logic [1:0] fcnt_r;
    logic dor_pend_r;
    wire fifo_push = rx_pend_r && fcnt_r != 2'h2;
    wire fifo_pop = rd_data && fcnt_r != 2'h0;
    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rx_st_r <= uart_pkg::RX_IDLE;
            rx_sh_r <= '0;
            rx_cnt_r <= '0;
            rx_par_r <= 1'b0;
            rx_perr_r <= 1'b0;
            rx_pend_r <= 1'b0;
            rx_hold_r <= '0;
            dor_pend_r <= 1'b0;
        end else if (!rxon_r) begin
            rx_st_r <= uart_pkg::RX_IDLE;
            rx_pend_r <= 1'b0;
            dor_pend_r <= 1'b0;
        end else begin
            if (fifo_push) begin
                rx_pend_r <= 1'b0;
                dor_pend_r <= 1'b0;
            end
            case (rx_st_r)
                uart_pkg::RX_IDLE: if (rx_start) begin
                    if (rx_pend_r && fcnt_r == 2'h2) begin
                        dor_pend_r <= 1'b1;
                    end
                    rx_cnt_r <= nbits;
                    rx_par_r <= csc_r[`CSC_PODD];
                    rx_st_r <= uart_pkg::RX_START;
                end
                uart_pkg::RX_START: if (rx_tick_r) begin
                    rx_st_r <= uart_pkg::RX_DATA;
                end
                uart_pkg::RX_DATA: if (rx_tick_r) begin
                    if (rx_cnt_r != 4'h0) begin
                        rx_sh_r <= {rxd_r, rx_sh_r[8:1]};
                        rx_par_r <= rx_par_r ^ rxd_r;
                        rx_cnt_r <= rx_cnt_r - 4'h1;
                        if (rx_cnt_r == 4'h1 && !par_en) begin
                            rx_st_r <= uart_pkg::RX_STOP;
                        end
                    end else begin
                        rx_perr_r <= rx_par_r ^ rxd_r;
                        rx_st_r <= uart_pkg::RX_STOP;
                    end
                end
                uart_pkg::RX_STOP: if (rx_tick_r) begin
                    rx_st_r <= uart_pkg::RX_IDLE;
                    if (rx_keep && !(rx_pend_r && fcnt_r == 2'h2)) begin
                        rx_pend_r <= 1'b1;
                        rx_hold_r <= {1'b0, par_en & rx_perr_r, !rx_stop_ok, rx_char};
                    end
                end
                default: rx_st_r <= uart_pkg::RX_IDLE;
            endcase
        end
    end
    wire [11:0] push_word = {dor_pend_r | rx_hold_r[11], rx_hold_r[10:0]};

    // Two-entry receive FIFO, head at index 0
    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            fcnt_r <= '0;
            fifo_r[0] <= '0;
            fifo_r[1] <= '0;
        end else if (!rxon_r) begin
            fcnt_r <= '0;
        end else begin
            case ({fifo_push, fifo_pop})
                2'b10: begin
                    fifo_r[fcnt_r[0]] <= push_word;
                    fcnt_r <= fcnt_r + 2'h1;
                end
                2'b01: begin
                    fifo_r[0] <= fifo_r[1];
                    fcnt_r <= fcnt_r - 2'h1;
                end
                2'b11: begin
                    if (fcnt_r == 2'h1) begin
                        fifo_r[0] <= push_word;
                    end else begin
                        fifo_r[0] <= fifo_r[1];
                        fifo_r[1] <= push_word;
                    end
                end
                default: fcnt_r <= fcnt_r;
            endcase
        end
    end
    wire rx_complete = fcnt_r != 2'h0;
    wire [11:0] head = rx_complete ? fifo_r[0] : 12'h000;

    // Register file and flags
    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            dbl_r <= 1'b0;
            mpf_r <= 1'b0;
            {rxie_r, txie_r, eie_r, rxon_r, txon_req_r, szh_r, tx9_r} <= '0;
            txon_r <= 1'b0;
            csc_r <= `CSC_RST;
            txc_r <= 1'b0;
            tx_buffer_empty_r <= 1'b1;
            txbuf_r <= '0;
        end else begin
            if (wr_csa) begin
                dbl_r <= i_wdata[`CSA_DBL];
                mpf_r <= i_wdata[`CSA_MPF];
            end
            if (wr_csb) begin
                rxie_r <= i_wdata[`CSB_RXIE];
                txie_r <= i_wdata[`CSB_TXIE];
                eie_r <= i_wdata[`CSB_EIE];
                rxon_r <= i_wdata[`CSB_RXON];
                txon_req_r <= i_wdata[`CSB_TXON];
                szh_r <= i_wdata[`CSB_SZH];
                tx9_r <= i_wdata[`CSB_TX9];
            end
            if (wr_csc) begin
                csc_r <= {1'b0, i_wdata[6:0]};
            end
            if (txon_req_r) begin
                txon_r <= 1'b1;
            end else if (tx_buffer_empty_r && !tx_busy) begin
                txon_r <= 1'b0;
            end
            if (wr_data && tx_buffer_empty_r) begin
                txbuf_r <= mask_char({tx9_r, i_wdata}, nbits);
                tx_buffer_empty_r <= 1'b0;
            end else if (tx_load) begin
                tx_buffer_empty_r <= 1'b1;
            end
            if (tx_done && tx_buffer_empty_r && !(wr_data && tx_buffer_empty_r)) begin
                txc_r <= 1'b1;
            end else if ((wr_csa && i_wdata[`CSA_TXC]) || i_tx_irq_ack) begin
                txc_r <= 1'b0;
            end
        end
    end
    wire [7:0] csa_val = {rx_complete, txc_r, tx_buffer_empty_r, head[9], head[11], head[10], dbl_r, mpf_r};
    wire [7:0] csb_val = {rxie_r, txie_r, eie_r, rxon_r, txon_req_r, szh_r, head[8], tx9_r};
    wire [7:0] rd_mux = (i_addr == `ADR_DATA) ? head[7:0] :
                        (i_addr == `ADR_CSA) ? csa_val :
                        (i_addr == `ADR_CSB) ? csb_val : csc_r;
    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= i_rd ? rd_mux : 8'h00;
        end
    end
    assign o_rdata = rdata_r;
    assign o_txd = txon_r ? txd_r : 1'b1;
    assign o_tx_pin_owned = txon_r;
    assign o_rx_pin_owned = rxon_r;
    assign o_irq_rx = rxie_r && i_global_ie && rx_complete;
    assign o_irq_tx = txie_r && i_global_ie && txc_r;
    assign o_irq_empty = eie_r && i_global_ie && tx_buffer_empty_r;

    chk_empty_reset: assert property (@(posedge i_clk) $rose(rst_n_r) |-> tx_buffer_empty_r)
        else $error("buffer empty not set after reset");
    chk_write_ignored: assert property (@(posedge i_clk) disable iff (!rst_n_r)
        (wr_data && !tx_buffer_empty_r) |=> $stable(txbuf_r))
        else $error("write while full altered buffer");
    chk_rxc_level: assert property (@(posedge i_clk) disable iff (!rst_n_r)
        (!rxon_r && !$past(rxon_r)) |-> !rx_complete)
        else $error("receive complete wrong");
    chk_fifo_pop: assert property (@(posedge i_clk) disable iff (!rst_n_r)
        (rd_data && rxon_r && fcnt_r == 2'h2 && !fifo_push) |=> fcnt_r == 2'h1)
        else $error("fifo did not advance on read");
    chk_irq_gate: assert property (@(posedge i_clk) disable iff (!rst_n_r)
        o_irq_tx |-> (txie_r && i_global_ie && txc_r))
        else $error("tx interrupt without cause");
    chk_tx_off_wait: assert property (@(posedge i_clk) disable iff (!rst_n_r)
        $fell(txon_r) |-> $past(tx_buffer_empty_r && !tx_busy))
        else $error("transmitter disabled while busy");
    chk_txc_set: assert property (@(posedge i_clk) disable iff (!rst_n_r)
        (tx_done && tx_buffer_empty_r && !wr_data) |=> txc_r)
        else $error("transmit complete not set");
    chk_filter_drop: assert property (@(posedge i_clk) disable iff (!rst_n_r)
        (rx_frame && rxon_r && mpf_r && !rx_marker && !rx_pend_r) |=> !rx_pend_r)
        else $error("filtered frame accepted");
    chk_load_shift: assert property (@(posedge i_clk) disable iff (!rst_n_r)
        tx_load |=> (tx_st_r == uart_pkg::TX_START && tx_buffer_empty_r))
        else $error("buffered char not loaded");
endmodule // uart_buffer_status_multiproc_filter

// *** verilog/uart_cfg.svh ***
/*
 * Offsets, field positions, reset values and timing counts of the serial transceiver.
 * Assumes inclusion by bare name from design files.
 */
`ifndef UART_CFG_SVH
`define UART_CFG_SVH
`define ADR_DATA 2'h0
`define ADR_CSA 2'h1
`define ADR_CSB 2'h2
`define ADR_CSC 2'h3
`define CSA_RXC 7
`define CSA_TXC 6
`define CSA_TX_BUFFER_EMPTY 5
`define CSA_FE 4
`define CSA_DOR 3
`define CSA_UPE 2
`define CSA_DBL 1
`define CSA_MPF 0
`define CSB_RXIE 7
`define CSB_TXIE 6
`define CSB_EIE 5
`define CSB_RXON 4
`define CSB_TXON 3
`define CSB_SZH 2
`define CSB_RX9 1
`define CSB_TX9 0
`define CSC_PEN 5
`define CSC_PODD 4
`define CSC_STOP2 3
`define CSC_SZ1 2
`define CSC_SZ0 1
`define CSC_RST 8'h06
`define DIV_NORMAL 5'h10
`define DIV_DOUBLE 5'h08
`define DIV_BITS 5
`endif

// *** verilog/uart_pkg.sv ***
/*
 * Types shared by the serial transceiver.
 * Assumes the compile order header, package, module.
 */
package uart_pkg;
    typedef enum logic [3:0] {
        TX_IDLE = 4'b0001,
        TX_START = 4'b0010,
        TX_DATA = 4'b0100,
        TX_STOP = 4'b1000
    } tx_state_e;
    typedef enum logic [3:0] {
        RX_IDLE = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA = 4'b0100,
        RX_STOP = 4'b1000
    } rx_state_e;
endpackage
